// File: hw/flash_clock_and_security_options.sv
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`include "flash_opt_consts.svh"
module flash_clock_and_security_options (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Access source sideband, same clock as the bus
  input wire logic debug_source,
  // Nonvolatile array contents
  input wire logic [7:0] nonvolatile_option_byte,
  input wire logic [63:0] stored_unlock_key,
  input wire logic blank_check_ok,
  // Erase and program requests from the sequencer
  input wire logic pe_request,
  input wire logic [7:0] pe_pulse_count,
  output logic pe_busy,
  output logic pe_done,
  output logic pe_refused,
  // Timebase and security outputs
  output logic flash_timebase_tick,
  output logic secure_state,
  output logic unsecured_access_block,
  output logic vector_remap_enable
);
  import flash_opt_pkg::*;

  state_t st;
  state_t next_st;
  logic req_cycle;
  logic ack_cycle;
  logic pre_tick;
  logic [1:0] lock_state_code;
  logic [7:0] key_byte;

  // Answer comes one edge after the request, so writes commit there
  assign req_cycle = (read || write) && st.waitreq;
  assign ack_cycle = (read || write) && !st.waitreq;

  always_comb begin
    lock_state_code = st.opt[1:0];
    if (st.key_unlocked || st.blank_unlocked) begin
      lock_state_code = `LOCK_OPEN;
    end
    pre_tick = !st.prescale8 || (st.pre_cnt == `PRESCALE_LAST);
    key_byte = stored_unlock_key[{st.key_idx[2:0], 3'h0} +: 8];
  end

  always_comb begin
    next_st = st;
    next_st.waitreq = !req_cycle;
    next_st.done = 1'b0;
    next_st.refused = 1'b0;
    next_st.tick = 1'b0;

    // Shadow is latched once after reset release and then frozen
    if (!st.opt_loaded) begin
      next_st.opt_loaded = 1'b1;
      next_st.opt = nonvolatile_option_byte;
    end

    // Timebase divider
    next_st.pre_cnt = st.pre_cnt + 3'h1;
    if (pre_tick) begin
      if (st.div_cnt >= st.ratio) begin
        next_st.div_cnt = 6'h00;
        next_st.tick = 1'b1;
      end else begin
        next_st.div_cnt = st.div_cnt + 6'h01;
      end
    end

    // Register reads
    if (req_cycle && read) begin
      case (address)
        `OFS_RATIO: begin
          next_st.rdata = {24'h0, st.ratio_loaded, st.prescale8, st.ratio};
        end
        `OFS_OPTION: begin
          next_st.rdata = {24'h0, st.opt[7:6], 4'h0,
                           lock_state_code};
        end
        `OFS_KEYCTL: begin
          next_st.rdata = {26'h0, st.key_idx, st.secure, st.key_access};
        end
        default: begin
          next_st.rdata = 32'h0;
        end
      endcase
    end

    // Register writes take effect at the answering edge only
    if (ack_cycle && write) begin
      case (address)
        `OFS_RATIO: begin
          next_st.ratio_loaded = 1'b1;
          next_st.prescale8 = writedata[`BIT_PRESCALE];
          next_st.ratio = writedata[5:0];
        end
        `OFS_KEYCTL: begin
          if (!debug_source) begin
            next_st.key_access = writedata[`BIT_KEY_ENTRY];
            if (writedata[`BIT_KEY_ENTRY] && !st.key_access) begin
              next_st.key_idx = 4'h0;
              next_st.key_match = 1'b1;
            end
            // Closing key entry runs the comparison
            if (!writedata[`BIT_KEY_ENTRY] && st.key_access &&
                st.key_match && st.key_idx == `KEY_BYTES &&
                st.opt[`BIT_BACKDOOR]) begin
              next_st.key_unlocked = 1'b1;
            end
          end
        end
        `OFS_KEYDATA: begin
          // Debug writes never advance the key sequence
          if (st.key_access && !debug_source) begin
            if (st.key_idx == `KEY_BYTES) begin
              next_st.key_match = 1'b0;
            end else begin
              next_st.key_idx = st.key_idx + 4'h1;
              if (writedata[7:0] != key_byte) begin
                next_st.key_match = 1'b0;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end

    if (blank_check_ok) begin
      next_st.blank_unlocked = 1'b1;
    end

    next_st.secure = (lock_state_code != `LOCK_OPEN);
    next_st.remap_en = !st.opt[`BIT_REMAP_OFF];

    // Erase and program timing, counted in timebase ticks; the first pulse can end one clock after the start
    // A refused request must not swallow a pulse of the running operation
    if (st.busy && st.tick) begin
      next_st.pulses_left = st.pulses_left - 8'h01;
      if (st.pulses_left == 8'h01) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
    if (pe_request) begin
      if (!st.ratio_loaded || st.busy) begin
        next_st.refused = 1'b1;
      end else begin
        next_st.busy = 1'b1;
        next_st.pulses_left = (pe_pulse_count == 8'h00) ? 8'h01 :
                              pe_pulse_count;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.waitreq <= 1'b1;
      st.opt <= `OPT_RST;
      st.ratio <= `RATIO_RST;
      st.key_match <= 1'b1;
      st.secure <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign readdata = st.rdata;
  assign waitrequest = st.waitreq;
  assign pe_busy = st.busy;
  assign pe_done = st.done;
  assign pe_refused = st.refused;
  assign flash_timebase_tick = st.tick;
  assign secure_state = st.secure;
  assign unsecured_access_block = st.secure;
  assign vector_remap_enable = st.remap_en;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_loaded_sticky: assert property (
    st.ratio_loaded |=> st.ratio_loaded)
    else $error("ratio loaded flag cleared without reset");

  a_first_write: assert property (
    ack_cycle && write && address == `OFS_RATIO |=> st.ratio_loaded)
    else $error("ratio write did not set loaded flag");

  a_refuse_unloaded: assert property (
    pe_request && !st.ratio_loaded |=> pe_refused && !pe_busy)
    else $error("erase or program accepted before ratio load");

  a_prescale_gate: assert property (
    st.prescale8 && st.pre_cnt != `PRESCALE_LAST |=> !st.tick)
    else $error("timebase tick off the prescaler boundary");

  a_div_by_one: assert property (
    !st.prescale8 && st.ratio == 6'h00 && st.div_cnt == 6'h00
    |=> st.tick)
    else $error("ratio zero does not tick every clock");

  a_busy_end: assert property (
    $fell(pe_busy) |-> $past(st.tick) && pe_done)
    else $error("operation ended off a timebase edge");

  a_shadow_frozen: assert property (
    st.opt_loaded |=> $stable(st.opt))
    else $error("option shadow changed after capture");

  a_key_disabled: assert property (
    !st.opt[`BIT_BACKDOOR] && st.opt_loaded |=> !$rose(st.key_unlocked))
    else $error("key unlocked with backdoor disabled");

  a_debug_key: assert property (
    ack_cycle && write && debug_source |=> $stable(st.key_idx))
    else $error("debug write advanced key sequence");

  a_lock_decode: assert property (
    ##1 secure_state == ($past(lock_state_code) != `LOCK_OPEN))
    else $error("security decode wrong");

  a_remap: assert property (
    st.opt_loaded |=> vector_remap_enable == !$past(st.opt[`BIT_REMAP_OFF]))
    else $error("vector remap output wrong");

  a_blank_open: assert property (
    blank_check_ok |=> ##1 !secure_state)
    else $error("blank check did not unsecure");

  a_bus_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");

  a_refuse_busy: assert property (
    pe_request && pe_busy |=> pe_refused)
    else $error("request accepted while busy");

  a_accept_loaded: assert property (
    pe_request && st.ratio_loaded && !pe_busy |=> pe_busy && !pe_refused)
    else $error("request refused after ratio load");

  a_pulse_hold: assert property (
    pe_busy && !st.tick |=> $stable(st.pulses_left))
    else $error("pulse count moved without a timebase tick");

  a_pulse_step: assert property (
    pe_busy && st.tick |=> st.pulses_left == $past(st.pulses_left) - 8'h01)
    else $error("pulse count missed a timebase tick");

  a_key_needs_match: assert property (
    $rose(st.key_unlocked) |->
    $past(st.key_match) && $past(st.key_idx) == `KEY_BYTES)
    else $error("unlock without a full matching key");

  a_key_entry_step: assert property (
    ack_cycle && write && address == `OFS_KEYDATA && st.key_access &&
    !debug_source && st.key_idx != `KEY_BYTES
    |=> st.key_idx == $past(st.key_idx) + 4'h1)
    else $error("key byte did not advance the sequence");

  a_debug_ctl: assert property (
    ack_cycle && write && debug_source
    |=> $stable(st.key_access) && $stable(st.key_unlocked))
    else $error("debug write touched key entry");

  a_open_sticky: assert property (
    !secure_state |=> !secure_state)
    else $error("security came back before reset");

  a_blank_sticky: assert property (
    st.blank_unlocked |=> st.blank_unlocked)
    else $error("blank check unlock lost before reset");

  a_block_decode: assert property (
    ##1 unsecured_access_block == ($past(lock_state_code) != `LOCK_OPEN))
    else $error("access block does not follow security");

  a_read_padding: assert property (
    read && !waitrequest |-> readdata[31:8] == 24'h0 &&
    (address != `OFS_OPTION || readdata[5:2] == 4'h0))
    else $error("unused read bits not zero");

  a_ratio_readback: assert property (
    read && !waitrequest && address == `OFS_RATIO |->
    readdata[`BIT_LOADED] == st.ratio_loaded)
    else $error("loaded flag read back wrong");

  a_tick_gap: assert property (
    flash_timebase_tick && (st.prescale8 || st.ratio != 6'h00)
    |=> !flash_timebase_tick)
    else $error("timebase ticked twice in a row");

  c_key_unlock: cover property ($rose(st.key_unlocked));
  c_refused: cover property (pe_refused);
  c_op_done: cover property (pe_done);
  c_blank: cover property ($rose(st.blank_unlocked));
  c_pe_start: cover property ($rose(pe_busy));
endmodule : flash_clock_and_security_options

// File: hw/flash_opt_consts.svh
`ifndef FLASH_OPT_CONSTS_SVH
`define FLASH_OPT_CONSTS_SVH
`define OFS_RATIO 4'h0
`define OFS_OPTION 4'h4
`define OFS_KEYCTL 4'h8
`define OFS_KEYDATA 4'hC
`define BIT_LOADED 7
`define BIT_PRESCALE 6
`define BIT_BACKDOOR 7
`define BIT_REMAP_OFF 6
`define BIT_KEY_ENTRY 0
`define RATIO_RST 6'h00
`define OPT_RST 8'hFF
`define LOCK_OPEN 2'b10
`define KEY_BYTES 4'h8
`define PRESCALE_LAST 3'h7
`define TB_MIN_KHZ 150
`define TB_MAX_KHZ 200
`define CLK_MHZ 50
`endif

// File: hw/flash_opt_pkg.sv
package flash_opt_pkg;
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic opt_loaded;
    logic [7:0] opt;
    logic ratio_loaded;
    logic prescale8;
    logic [5:0] ratio;
    logic [2:0] pre_cnt;
    logic [5:0] div_cnt;
    logic tick;
    logic key_access;
    logic [3:0] key_idx;
    logic key_match;
    logic key_unlocked;
    logic blank_unlocked;
    logic secure;
    logic remap_en;
    logic busy;
    logic [7:0] pulses_left;
    logic done;
    logic refused;
  } state_t;
endpackage : flash_opt_pkg

// File: tb/flash_clock_and_security_options_tb_top.sv
`timescale 1ns/100ps
`include "flash_opt_consts.svh"
module flash_clock_and_security_options_tb_top;
  logic clock = 0, rstn = 0, read = 0, write = 0, dbg = 0, blank = 0;
  logic req = 0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic waitrequest, busy, done, refused, tick, sec, blk, remap;
  logic [7:0] nv = 8'hBF, cnt = 8'h00;
  logic [63:0] key = 64'h0;
  logic [5:0] r;
  logic [31:0] rq[$];
  int failures = 0, checks = 0, seed = 2;

  flash_clock_and_security_options dut (.clock(clock), .rstn(rstn),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .debug_source(dbg),
    .nonvolatile_option_byte(nv), .stored_unlock_key(key),
    .blank_check_ok(blank), .pe_request(req), .pe_pulse_count(cnt),
    .pe_busy(busy), .pe_done(done), .pe_refused(refused),
    .flash_timebase_tick(tick), .secure_state(sec),
    .unsecured_access_block(blk), .vector_remap_enable(remap));

  initial forever #10 clock = ~clock;

  task results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Request held until the edge that samples waitrequest low
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h0, d};
    write <= w;
    read <= !w;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    write <= 0;
    read <= 0;
    @(posedge clock);
  endtask : bus

  task rd(input logic [3:0] a, input logic [7:0] e);
    rq.push_back({24'h0, e});
    bus(0, a, 8'h00);
  endtask : rd

  always @(posedge clock) begin
    if (read && waitrequest === 1'b0)
      chk("readdata", rq.pop_front(), readdata);
  end

  // Skips two ticks so a ratio change mid-count cannot skew the figure
  task period(input int e);
    int n;
    n = 0;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (tick !== 1'b1 && n < 600);
    end
    chk("tick period", e, n);
  endtask : period

  task rst(input logic [7:0] v);
    rstn <= 0;
    nv <= v;
    repeat (10) @(posedge clock);
    rstn <= 1;
    repeat (4) @(posedge clock);
  endtask : rst

  task pe(input logic ok);
    int n, t;
    n = 0;
    req <= 1;
    cnt <= 8'h03;
    @(posedge clock);
    req <= 0;
    @(posedge clock);
    chk("refused", !ok, refused);
    chk("busy", ok, busy);
    if (ok) begin
      t = (tick === 1'b1);
      req <= 1;
      while (done !== 1'b1 && n < 1500) begin
        @(posedge clock);
        n++;
        if (tick === 1'b1) t++;
        if (n == 1) req <= 0;
        if (n == 2) chk("refused busy", 1, refused);
      end
      chk("pulses", 3, 32'(t));
      chk("done", 1, done);
      chk("busy end", 0, busy);
    end
  endtask : pe

  task keys(input logic d, input logic [63:0] k);
    dbg <= d;
    bus(1, `OFS_KEYCTL, 8'h01);
    for (int i = 0; i < 8; i++) bus(1, `OFS_KEYDATA, k[8*i +: 8]);
    bus(1, `OFS_KEYCTL, 8'h00);
    dbg <= 0;
    repeat (2) @(posedge clock);
  endtask : keys

  task secchk(input logic e);
    chk("secure", e, sec);
    chk("block", e, blk);
  endtask : secchk

  initial begin
    key = {$random(seed), $random(seed)};
    rst(8'hBF);
    secchk(1);
    chk("remap", 1, remap);
    rd(`OFS_OPTION, 8'h83);
    rd(`OFS_RATIO, 8'h00);
    pe(0);
    bus(1, `OFS_OPTION, 8'h00);
    rd(`OFS_OPTION, 8'h83);
    rd(4'h2, 8'h00);
    $display("reset and refusal test done");
    r = 6'($unsigned($random(seed)) % 7 + 1);
    bus(1, `OFS_RATIO, {2'b00, r});
    rd(`OFS_RATIO, {2'b10, r});
    period(r + 1);
    // 150 to 200 kHz at 50 MHz needs prescale and a ratio of 31 to 40
    r = 6'($unsigned($random(seed)) % 10 + 31);
    bus(1, `OFS_RATIO, {2'b01, r});
    rd(`OFS_RATIO, {2'b11, r});
    period(8 * (r + 1));
    pe(1);
    $display("divider test done");
    keys(1, key);
    secchk(1);
    keys(0, key ^ 64'h1);
    secchk(1);
    keys(0, key);
    secchk(0);
    rd(`OFS_OPTION, 8'h82);
    $display("key test done");
    rst(8'h7C);
    secchk(1);
    chk("remap", 0, remap);
    rd(`OFS_OPTION, 8'h40);
    keys(0, key);
    secchk(1);
    blank <= 1;
    @(posedge clock);
    blank <= 0;
    repeat (4) @(posedge clock);
    secchk(0);
    rd(`OFS_OPTION, 8'h42);
    $display("blank check test done");
    results();
  end

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    results();
  end
endmodule : flash_clock_and_security_options_tb_top
